// file: hw/tss_pkg.sv
// Shared constants, field layouts and types of the timeslot switch.
package tss_pkg;
  // Serial framing: 32.768 Mbps streams in 125 us frames carry 4096 bits, 512 channels.
  localparam int STREAMS = 8;
  localparam int FRAME_BITS = 4096;
  localparam int CAP_LAT = 31;
  localparam logic [11:0] CAP_RESTART = 12'(FRAME_BITS - CAP_LAT);
  localparam int RUN_DETECT = 16;
  localparam int START_FRAMES = 2;
  // Synchroniser lanes for every pin other than the reset that comes from outside the core clock domain.
  localparam int NPINS = 22;
  localparam int PIN_FP = 16;
  localparam int PIN_MCLK = 17;
  localparam int PIN_TCK = 18;
  localparam int PIN_TMS = 19;
  localparam int PIN_TDI = 20;
  localparam int PIN_TRST = 21;
  // Register word offsets, reached with address bit 14 low.
  localparam logic [14:0] REG_CTRL = 15'h0000;
  localparam logic [14:0] REG_BLOCK = 15'h0001;
  localparam logic [14:0] REG_BIDR_BASE = 15'h0010;
  localparam logic [14:0] REG_LIDR_BASE = 15'h0018;
  localparam logic [14:0] REG_BOAR_BASE = 15'h0020;
  localparam logic [14:0] REG_LOAR_BASE = 15'h0028;
  localparam logic [14:0] REG_BIST = 15'h0030;
  localparam logic [14:0] REG_STATUS = 15'h0031;
  localparam int ADDR_MEM_SEL = 14;
  // Memory regions, selected by address bits 13:12 when bit 14 is high.
  localparam logic [1:0] MEM_BDM = 2'h0;
  localparam logic [1:0] MEM_LDM = 2'h1;
  localparam logic [1:0] MEM_BCM = 2'h2;
  localparam logic [1:0] MEM_LCM = 2'h3;
  // Connection memory entry layout.
  localparam int CM_MODE_LSB = 14;
  localparam int CM_SRC_PORT = 13;
  localparam int CM_SRC_STR_LSB = 9;
  // Register fields and reset values.
  localparam int CTRL_ODE = 0;
  localparam logic [15:0] CTRL_RST = 16'h0001;
  localparam int BLK_START = 15;
  localparam int BLK_BMODE_LSB = 13;
  localparam int BLK_LMODE_LSB = 11;
  localparam int BIST_START = 0;
  localparam logic [15:0] BIST_PATTERN = 16'ha5c3;
  localparam logic [1:0] IR_IDCODE = 2'h1;
  // Per-channel output modes held in connection memory.
  typedef enum logic [1:0] {MODE_CONN = 2'h0, MODE_MSG = 2'h1, MODE_HIZ = 2'h2, MODE_HIGH = 2'h3} tss_mode_t;
  typedef enum logic [1:0] {OP_IDLE, OP_FILL, OP_BIST_WR, OP_BIST_RD} tss_op_t;
  typedef enum logic [3:0] {TAP_TLR, TAP_RTI, TAP_SELDR, TAP_CAPDR, TAP_SHDR, TAP_EX1DR, TAP_PAUDR, TAP_EX2DR,
    TAP_UPDR, TAP_SELIR, TAP_CAPIR, TAP_SHIR, TAP_EX1IR, TAP_PAUIR, TAP_EX2IR, TAP_UPIR} tss_tap_t;
  // Flip-flop state of the switch apart from the reset synchroniser, ports indexed 0 for backplane and 1 for local.
  typedef struct packed {
    logic [NPINS-1:0] s1, s2, s3, lvl;
    logic det, pol, run_lvl, fp_prev, active;
    logic [4:0] run;
    logic [1:0] start_cnt, frame, cap_frame, seq_frame;
    logic [11:0] bit_cnt, cap_bit, op_cnt;
    logic [1:0][7:0][31:0] dly;
    logic [1:0][7:0][7:0] in_sh, nxt, osh;
    logic [1:0][7:0][1:0] nmode, omode, adv;
    logic [1:0][7:0][4:0] in_dly;
    logic [1:0][7:0] out_d, out_oe_b;
    logic seq_run;
    logic [3:0] seq;
    logic [8:0] seq_chan;
    logic [15:0] ctrl, blk, rdata;
    tss_op_t op;
    logic bist_done, bist_pass, ack;
    tss_tap_t tap_st;
    logic [1:0] ir, ir_sh;
    logic [31:0] dr_sh;
    logic tdo, tdo_oe_b, gen_fast, gen_slow, gen_fp_fast, gen_fp_slow;
  } tss_state_t;
endpackage

// file: hw/tss_switch.sv
// Two-port time-division channel switch with a parallel host port and a test access port.
//
// Implementation choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
module tss_switch #(
  parameter logic [31:0] IDCODE = 32'h0000_0001 // Arbitrary identification value.
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [14:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [15:0] avs_writedata,
  output logic [15:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [tss_pkg::STREAMS-1:0] bp_in,
  input wire logic [tss_pkg::STREAMS-1:0] lo_in,
  output logic [tss_pkg::STREAMS-1:0] bp_out,
  output logic [tss_pkg::STREAMS-1:0] bp_out_oe_b,
  output logic [tss_pkg::STREAMS-1:0] lo_out,
  output logic [tss_pkg::STREAMS-1:0] lo_out_oe_b,
  input wire logic master_frame_pulse_in,
  input wire logic master_clock_in,
  output logic gen_frame_pulse_slow_out,
  output logic gen_frame_pulse_fast_out,
  output logic gen_clock_slow_out,
  output logic gen_clock_fast_out,
  input wire logic jtag_tck,
  input wire logic jtag_tms,
  input wire logic jtag_tdi,
  input wire logic jtag_trst_b,
  output logic jtag_tdo,
  output logic jtag_tdo_oe_b
);
  import tss_pkg::*;

  tss_state_t s, d; // Registered state and its next value.
  logic rst_meta_q, rst_q; // Released copy of the asynchronous reset.
  logic mrise, frame_start, trise, tfall; // Single-cycle events found this cycle.
  logic [1:0] dm_we, cm_we; // Memory write strobes per port.
  logic [10:0] dm_wa; // Data memory slot: frame buffer and channel.
  logic [11:0] cm_wa; // Connection memory slot: stream and channel.
  logic [1:0][63:0] dm_wd; // Eight captured bytes of one channel per port.
  logic [1:0][15:0] cm_wd; // Connection entries to store.
  logic [15:0] fetch_entry; // Entry being fetched for the next channel.
  logic [7:0] fetch_byte; // Source byte that entry points at.
  logic [63:0] dmem [0:1][0:2047]; // Four frame buffers of 512 channels x 8 streams.
  logic [15:0] cmem [0:1][0:4095]; // One connection memory per output port.

  // Standard test-port state walk on each rising test clock.
  function automatic tss_tap_t tap_next(input tss_tap_t st, input logic tms);
    unique case (st)
      TAP_TLR: tap_next = tms ? TAP_TLR : TAP_RTI;
      TAP_RTI: tap_next = tms ? TAP_SELDR : TAP_RTI;
      TAP_SELDR: tap_next = tms ? TAP_SELIR : TAP_CAPDR;
      TAP_CAPDR: tap_next = tms ? TAP_EX1DR : TAP_SHDR;
      TAP_SHDR: tap_next = tms ? TAP_EX1DR : TAP_SHDR;
      TAP_EX1DR: tap_next = tms ? TAP_UPDR : TAP_PAUDR;
      TAP_PAUDR: tap_next = tms ? TAP_EX2DR : TAP_PAUDR;
      TAP_EX2DR: tap_next = tms ? TAP_UPDR : TAP_SHDR;
      TAP_UPDR: tap_next = tms ? TAP_SELDR : TAP_RTI;
      TAP_SELIR: tap_next = tms ? TAP_TLR : TAP_CAPIR;
      TAP_CAPIR: tap_next = tms ? TAP_EX1IR : TAP_SHIR;
      TAP_SHIR: tap_next = tms ? TAP_EX1IR : TAP_SHIR;
      TAP_EX1IR: tap_next = tms ? TAP_UPIR : TAP_PAUIR;
      TAP_PAUIR: tap_next = tms ? TAP_EX2IR : TAP_PAUIR;
      TAP_EX2IR: tap_next = tms ? TAP_UPIR : TAP_SHIR;
      TAP_UPIR: tap_next = tms ? TAP_SELDR : TAP_RTI;
    endcase
  endfunction

  // Reset is released through two flops so every state flop leaves reset on the same edge.
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_q <= 1'b0;
      rst_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_q <= rst_meta_q;
    end
  end

  // All behaviour of the switch is computed here from the current state.
  always_comb
  begin
    d = s;
    dm_we = 2'b00;
    cm_we = 2'b00;
    dm_wa = 11'h000;
    cm_wa = 12'h000;
    dm_wd = '0;
    cm_wd = '0;
    // Pins pass three flops; a level is accepted only once the last two agree.
    d.s1 = {jtag_trst_b, jtag_tdi, jtag_tms, jtag_tck, master_clock_in, master_frame_pulse_in, lo_in, bp_in};
    d.s2 = s.s1;
    d.s3 = s.s2;
    for (int i = 0; i < NPINS; i++)
    begin
      if (s.s2[i] == s.s3[i])
        d.lvl[i] = s.s3[i];
    end
    mrise = d.lvl[PIN_MCLK] & ~s.lvl[PIN_MCLK];
    trise = d.lvl[PIN_TCK] & ~s.lvl[PIN_TCK];
    tfall = ~d.lvl[PIN_TCK] & s.lvl[PIN_TCK];
    frame_start = 1'b0;
    // Fetch one output's next byte per core cycle: eight backplane entries, then eight local.
    fetch_entry = cmem[s.seq[3]][{s.seq[2:0], s.seq_chan}];
    fetch_byte = dmem[fetch_entry[CM_SRC_PORT]][{s.seq_frame, fetch_entry[8:0]}]
      [{fetch_entry[CM_SRC_STR_LSB +: 3], 3'b000} +: 8];
    if (s.seq_run)
    begin
      if (fetch_entry[CM_MODE_LSB +: 2] == MODE_MSG)
        d.nxt[s.seq[3]][s.seq[2:0]] = fetch_entry[7:0];
      else
        d.nxt[s.seq[3]][s.seq[2:0]] = fetch_byte;
      d.nmode[s.seq[3]][s.seq[2:0]] = fetch_entry[CM_MODE_LSB +: 2];
      d.seq = s.seq + 4'h1;
      d.seq_run = (s.seq != 4'hf);
    end
    d.gen_fast = d.lvl[PIN_MCLK];
    if (mrise)
    begin
      // The pulse's idle level is the one that holds for a long run; the active level is its opposite.
      if (!s.det)
      begin
        if (d.lvl[PIN_FP] != s.run_lvl)
        begin
          d.run = 5'h00;
          d.run_lvl = d.lvl[PIN_FP];
        end
        else if (s.run != 5'(RUN_DETECT))
          d.run = s.run + 5'h01;
        else
        begin
          d.det = 1'b1;
          d.pol = ~s.run_lvl;
        end
      end
      frame_start = s.det && (d.lvl[PIN_FP] == s.pol) && (s.fp_prev != s.pol);
      d.fp_prev = d.lvl[PIN_FP];
      d.bit_cnt = frame_start ? 12'h000 : s.bit_cnt + 12'h001;
      if (frame_start)
      begin
        d.frame = s.frame + 2'h1;
        if (s.start_cnt != 2'(START_FRAMES))
          d.start_cnt = s.start_cnt + 2'h1;
        d.active = (d.start_cnt == 2'(START_FRAMES));
      end
      // Capture runs a fixed distance behind the frame so every stream delay lands on one grid.
      d.cap_bit = frame_start ? CAP_RESTART : s.cap_bit + 12'h001;
      if (d.cap_bit == 12'h000)
        d.cap_frame = d.frame;
      for (int p = 0; p < 2; p++)
      begin
        for (int i = 0; i < STREAMS; i++)
        begin
          d.dly[p][i] = {s.dly[p][i][30:0], d.lvl[p * STREAMS + i]};
          d.in_sh[p][i] = {s.in_sh[p][i][6:0], d.dly[p][i][5'(CAP_LAT) - s.in_dly[p][i]]};
          // A stream advanced by n bits starts each channel n bit times early.
          if (3'(d.bit_cnt[2:0] + {1'b0, s.adv[p][i]}) == 3'h0)
          begin
            d.osh[p][i] = s.nxt[p][i];
            d.omode[p][i] = s.nmode[p][i];
          end
          else
            d.osh[p][i] = {s.osh[p][i][6:0], 1'b0};
          d.out_oe_b[p][i] = (d.omode[p][i] == MODE_HIZ);
          d.out_d[p][i] = (d.omode[p][i] == MODE_HIGH) | d.osh[p][i][7];
        end
      end
      if (s.det && d.cap_bit[2:0] == 3'h7)
      begin
        dm_we = 2'b11;
        dm_wa = {d.cap_frame, d.cap_bit[11:3]};
        dm_wd = d.in_sh;
      end
      // Each channel start fetches the next channel, from the buffer filled two frames earlier.
      if (d.bit_cnt[2:0] == 3'h0)
      begin
        d.seq_run = 1'b1;
        d.seq = 4'h0;
        d.seq_chan = d.bit_cnt[11:3] + 9'h001;
        d.seq_frame = d.frame - 2'h2 + {1'b0, &d.bit_cnt[11:3]};
      end
      d.gen_slow = ~s.gen_slow;
      d.gen_fp_fast = ~frame_start;
      d.gen_fp_slow = ~(frame_start || d.bit_cnt == 12'h001);
    end
    if (!s.active || !s.ctrl[CTRL_ODE])
      d.out_oe_b = '1;
    // Bulk fill and self-test own both connection memories while they run.
    unique case (s.op)
      OP_IDLE:
      begin
      end
      OP_FILL:
      begin
        cm_we = 2'b11;
        cm_wa = s.op_cnt;
        cm_wd[0] = {s.blk[BLK_BMODE_LSB +: 2], 14'h0000};
        cm_wd[1] = {s.blk[BLK_LMODE_LSB +: 2], 14'h0000};
      end
      OP_BIST_WR:
      begin
        cm_we = 2'b11;
        cm_wa = s.op_cnt;
        cm_wd[0] = BIST_PATTERN ^ {4'h0, s.op_cnt};
        cm_wd[1] = BIST_PATTERN ^ {4'h0, s.op_cnt};
      end
      OP_BIST_RD:
      begin
        if (cmem[0][s.op_cnt] != (BIST_PATTERN ^ {4'h0, s.op_cnt})
          || cmem[1][s.op_cnt] != (BIST_PATTERN ^ {4'h0, s.op_cnt}))
          d.bist_pass = 1'b0;
      end
    endcase
    if (s.op != OP_IDLE)
    begin
      d.op_cnt = s.op_cnt + 12'h001;
      if (s.op_cnt == 12'hfff)
      begin
        d.op = (s.op == OP_BIST_WR) ? OP_BIST_RD : OP_IDLE;
        d.bist_done = (s.op == OP_BIST_RD);
        if (s.op == OP_FILL)
          d.blk[BLK_START] = 1'b0;
      end
    end
    // Every request waits exactly one cycle; data and writes act on the second.
    d.ack = (avs_read | avs_write) & ~s.ack;
    if (avs_read && !s.ack)
    begin
      d.rdata = 16'h0000;
      if (avs_address[ADDR_MEM_SEL])
      begin
        unique case (avs_address[13:12])
          MEM_BDM, MEM_LDM:
            d.rdata = {8'h00, dmem[avs_address[12]][{s.frame - 2'h1, avs_address[8:0]}]
              [{avs_address[11:9], 3'b000} +: 8]};
          MEM_BCM, MEM_LCM:
            d.rdata = cmem[avs_address[12]][avs_address[11:0]];
        endcase
      end
      else if (avs_address == REG_CTRL)
        d.rdata = s.ctrl;
      else if (avs_address == REG_BLOCK)
        d.rdata = s.blk;
      else if (avs_address == REG_BIST)
        d.rdata = {14'h0000, s.bist_pass, s.bist_done};
      else if (avs_address == REG_STATUS)
        d.rdata = {11'h000, s.op != OP_IDLE, s.active, s.pol, s.det, s.bist_pass};
      else if (avs_address[14:3] == REG_BIDR_BASE[14:3])
        d.rdata = {11'h000, s.in_dly[0][avs_address[2:0]]};
      else if (avs_address[14:3] == REG_LIDR_BASE[14:3])
        d.rdata = {11'h000, s.in_dly[1][avs_address[2:0]]};
      else if (avs_address[14:3] == REG_BOAR_BASE[14:3])
        d.rdata = {14'h0000, s.adv[0][avs_address[2:0]]};
      else if (avs_address[14:3] == REG_LOAR_BASE[14:3])
        d.rdata = {14'h0000, s.adv[1][avs_address[2:0]]};
    end
    if (avs_write && s.ack)
    begin
      if (avs_address[ADDR_MEM_SEL])
      begin
        // Data memories ignore writes; connection writes are dropped during a fill or self-test.
        if (avs_address[13] && s.op == OP_IDLE)
        begin
          cm_we[avs_address[12]] = 1'b1;
          cm_wa = avs_address[11:0];
          cm_wd[avs_address[12]] = avs_writedata;
        end
      end
      else if (avs_address == REG_CTRL)
        d.ctrl = avs_writedata;
      else if (avs_address == REG_BLOCK && s.op == OP_IDLE)
      begin
        d.blk = avs_writedata;
        if (avs_writedata[BLK_START])
        begin
          d.op = OP_FILL;
          d.op_cnt = 12'h000;
        end
      end
      else if (avs_address == REG_BIST && s.op == OP_IDLE && avs_writedata[BIST_START])
      begin
        d.op = OP_BIST_WR;
        d.op_cnt = 12'h000;
        d.bist_done = 1'b0;
        d.bist_pass = 1'b1;
      end
      else if (avs_address[14:3] == REG_BIDR_BASE[14:3])
        d.in_dly[0][avs_address[2:0]] = avs_writedata[4:0];
      else if (avs_address[14:3] == REG_LIDR_BASE[14:3])
        d.in_dly[1][avs_address[2:0]] = avs_writedata[4:0];
      else if (avs_address[14:3] == REG_BOAR_BASE[14:3])
        d.adv[0][avs_address[2:0]] = avs_writedata[1:0];
      else if (avs_address[14:3] == REG_LOAR_BASE[14:3])
        d.adv[1][avs_address[2:0]] = avs_writedata[1:0];
    end
    // Test port: identification and bypass paths only, clocked by the sampled test clock.
    if (!d.lvl[PIN_TRST])
    begin
      d.tap_st = TAP_TLR;
      d.ir = IR_IDCODE;
    end
    else if (trise)
    begin
      if (s.tap_st == TAP_CAPDR)
        d.dr_sh = (s.ir == IR_IDCODE) ? IDCODE : 32'h0000_0000;
      if (s.tap_st == TAP_SHDR)
        d.dr_sh = (s.ir == IR_IDCODE) ? {d.lvl[PIN_TDI], s.dr_sh[31:1]} : {31'h0000_0000, d.lvl[PIN_TDI]};
      if (s.tap_st == TAP_CAPIR)
        d.ir_sh = 2'h1;
      if (s.tap_st == TAP_SHIR)
        d.ir_sh = {d.lvl[PIN_TDI], s.ir_sh[1]};
      if (s.tap_st == TAP_UPIR)
        d.ir = s.ir_sh;
      if (s.tap_st == TAP_TLR)
        d.ir = IR_IDCODE;
      d.tap_st = tap_next(s.tap_st, d.lvl[PIN_TMS]);
    end
    if (tfall)
    begin
      d.tdo = (s.tap_st == TAP_SHDR) ? s.dr_sh[0] : s.ir_sh[0];
      d.tdo_oe_b = ~(s.tap_st == TAP_SHDR || s.tap_st == TAP_SHIR);
    end
  end

  // State register; only constants are loaded under reset.
  always_ff @(posedge core_clk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      s <= '0;
      s.ctrl <= CTRL_RST;
      s.ir <= IR_IDCODE;
      s.out_oe_b <= '1;
      s.tdo_oe_b <= 1'b1;
      s.gen_fp_fast <= 1'b1;
      s.gen_fp_slow <= 1'b1;
    end
    else
      s <= d;
  end

  // Memories have no reset; software or the block fill initialises connections.
  always_ff @(posedge core_clk)
  begin
    for (int p = 0; p < 2; p++)
    begin
      if (dm_we[p])
        dmem[p][dm_wa] <= dm_wd[p];
      if (cm_we[p])
        cmem[p][cm_wa] <= cm_wd[p];
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~s.ack;
  assign avs_readdata = s.rdata;
  assign bp_out = s.out_d[0];
  assign bp_out_oe_b = s.out_oe_b[0];
  assign lo_out = s.out_d[1];
  assign lo_out_oe_b = s.out_oe_b[1];
  assign gen_clock_fast_out = s.gen_fast;
  assign gen_clock_slow_out = s.gen_slow;
  assign gen_frame_pulse_fast_out = s.gen_fp_fast;
  assign gen_frame_pulse_slow_out = s.gen_fp_slow;
  assign jtag_tdo = s.tdo;
  assign jtag_tdo_oe_b = s.tdo_oe_b;

  // Checks on the switch's own outputs and state.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_q);
  chk_hiz_before_start: assert property (!s.active |=> (&bp_out_oe_b) && (&lo_out_oe_b))
    else $error("Output driven before start-up completed.");
  chk_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("Bus request not answered after one wait cycle.");
  chk_status_read: assert property (avs_read && avs_waitrequest && avs_address == REG_STATUS
    |=> avs_readdata[3:1] == {$past(s.active), $past(s.pol), $past(s.det)})
    else $error("Status read does not show live state.");
  chk_dm_capture_only: assert property (|dm_we |-> mrise && s.det && d.cap_bit[2:0] == 3'h7)
    else $error("Data memory written outside a channel capture.");
  chk_start_after_frame: assert property ($rose(s.active) |-> $past(s.start_cnt) == 2'(START_FRAMES - 1))
    else $error("Switching enabled without two frame boundaries.");
  chk_msg_byte: assert property (s.seq_run && fetch_entry[CM_MODE_LSB +: 2] == MODE_MSG && !mrise
    |=> s.nxt[$past(s.seq[3])][$past(s.seq[2:0])] == $past(fetch_entry[7:0]))
    else $error("Message byte not taken from the connection entry.");
  chk_conn_byte: assert property (s.seq_run && fetch_entry[CM_MODE_LSB +: 2] == MODE_CONN && !mrise
    |=> s.nxt[$past(s.seq[3])][$past(s.seq[2:0])] == $past(fetch_byte))
    else $error("Connected byte not taken from data memory.");
  chk_fill_ends: assert property (s.op == OP_FILL && s.op_cnt == 12'hfff |=> s.op == OP_IDLE && !s.blk[BLK_START])
    else $error("Block fill did not finish after the last entry.");
  chk_hiz_channel: assert property (s.omode[1][0] == MODE_HIZ |-> lo_out_oe_b[0])
    else $error("Tristated channel is driven.");
  chk_high_channel: assert property (s.omode[0][0] == MODE_HIGH && !bp_out_oe_b[0] |-> bp_out[0])
    else $error("Driven-high channel output is low.");
  chk_frame_latency: assert property (mrise && d.bit_cnt[2:0] == 3'h0 |=> s.seq_frame == 2'(s.frame - 2'h2
    + {1'b0, &s.bit_cnt[11:3]}))
    else $error("Fetch does not read the buffer two frames back.");
  cov_switch_active: cover property ($rose(s.active));
  cov_fill_done: cover property (s.op == OP_FILL ##1 s.op == OP_IDLE);
  cov_bist_done: cover property ($rose(s.bist_done));
  cov_msg_fetch: cover property (s.seq_run && fetch_entry[CM_MODE_LSB +: 2] == MODE_MSG);
endmodule

// file: dv/tss_tdm_peer.sv
// Serial peer that supplies master timing and the input streams of both ports.
`timescale 1ns/1ps
module tss_tdm_peer import tss_pkg::*; (
  output logic master_clock_in,
  output logic master_frame_pulse_in,
  output logic [tss_pkg::STREAMS-1:0] bp_in,
  output logic [tss_pkg::STREAMS-1:0] lo_in
);
  // Bit position in the frame; starting late leaves the pulse idle for the polarity search.
  logic [11:0] bit_q;

  // The master clock runs free, and data and pulse move on its falling edge.
  initial
  begin
    bit_q = 12'h0064;
    master_clock_in = 1'b0;
    master_frame_pulse_in = 1'b1;
    bp_in = 8'h00;
    lo_in = 8'hff;
    #7;
    forever
    begin
      #80;
      master_clock_in = 1'b1;
      #80;
      master_clock_in = 1'b0;
      bit_q = bit_q + 12'h0001;
      master_frame_pulse_in = (bit_q != 12'h0000);
      bp_in = bit_q[7:0] ^ 8'h5a;
      lo_in = ~bit_q[7:0];
    end
  end
endmodule

// file: dv/tss_switch_tb.sv
// Self-checking bench of the timeslot switch against a serial peer.
`timescale 1ns/1ps
module tss_switch_tb;
  import tss_pkg::*;
  localparam logic [31:0] TB_IDCODE = 32'h1357_9bdf; // Arbitrary identification value.
  logic core_clk, rst_b, avs_read, avs_write, avs_waitrequest, mclk, mfp;
  logic jtag_tck, jtag_tms, jtag_trst_b, jtag_tdo, gfp_fast, gfp_slow;
  logic [31:0] tdo_bits; // Bits seen on the test data output, last one at the top.
  logic [14:0] avs_address;
  logic [15:0] avs_writedata, avs_readdata, last_rd, rnd, v;
  logic [7:0] bp_in, lo_in, bp_out, bp_oe_b, lo_out, lo_oe_b;
  logic [16:0] exp_q[$]; // Pending reads: check flag over the expected word.
  logic [16:0] ent;
  int miscompares, n_checks, cyc, nf, ns;

  tss_tdm_peer i_peer (.master_clock_in(mclk), .master_frame_pulse_in(mfp), .bp_in(bp_in), .lo_in(lo_in));

  // Test data input is held low; the identification path shifts it in and never shows it.
  tss_switch #(.IDCODE(TB_IDCODE)) i_dut (.core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .bp_in(bp_in), .lo_in(lo_in), .bp_out(bp_out), .bp_out_oe_b(bp_oe_b),
    .lo_out(lo_out), .lo_out_oe_b(lo_oe_b), .master_frame_pulse_in(mfp), .master_clock_in(mclk),
    .gen_frame_pulse_slow_out(gfp_slow), .gen_frame_pulse_fast_out(gfp_fast), .gen_clock_slow_out(),
    .gen_clock_fast_out(), .jtag_tck(jtag_tck), .jtag_tms(jtag_tms), .jtag_tdi(1'b0), .jtag_trst_b(jtag_trst_b),
    .jtag_tdo(jtag_tdo), .jtag_tdo_oe_b());

  // Xorshift source with a fixed start so every run repeats.
  function automatic logic [15:0] xs(input logic [15:0] s);
    s ^= s << 7;
    s ^= s >> 9;
    s ^= s << 8;
    return s;
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // One Avalon transfer; the request holds until the rising edge that samples waitrequest low.
  task automatic bus(input logic wr, input logic [14:0] a, input logic [15:0] d);
    @(posedge core_clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    if (!wr)
      last_rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // One slow test clock period; the output bit is taken just before the rise, long after the fall moved it.
  task automatic tck_pulse(input logic tms);
    @(posedge core_clk);
    jtag_tck <= 1'b0;
    jtag_tms <= tms;
    repeat (10) @(posedge core_clk);
    tdo_bits = {jtag_tdo, tdo_bits[31:1]};
    jtag_tck <= 1'b1;
    repeat (9) @(posedge core_clk);
  endtask

  // A read notes its expectation first; the watcher below makes the compare.
  task automatic rd(input logic [14:0] a, input logic chk, input logic [15:0] e);
    exp_q.push_back({chk, e});
    bus(1'b0, a, 16'h0000);
  endtask

  // Watcher: at the accepting edge of every read, the oldest note comes off the queue.
  always @(posedge core_clk)
    if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0)
    begin
      ent = exp_q.pop_front();
      if (ent[16])
        check("readdata", avs_readdata, ent[15:0]);
    end

  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Start-up takes about two frames and the later fill and self-test a fifth more; the ceiling sits above that.
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 95000)
    begin
      miscompares++;
      finish_test();
    end
  end

  initial
  begin
    rst_b = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 15'h0000;
    avs_writedata = 16'h0000;
    jtag_tck = 1'b0;
    jtag_tms = 1'b1;
    jtag_trst_b = 1'b0;
    tdo_bits = 32'h0000_0000;
    rnd = 16'hb37e;
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    jtag_trst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    check("start oe", {bp_oe_b, lo_oe_b}, 16'hffff);
    rd(REG_CTRL, 1'b1, CTRL_RST);
    rd(15'h0100, 1'b1, 16'h0000);
    // Delay and advance registers of every stream, each written with a random value and read back.
    for (int k = 0; k < 32; k++)
    begin
      rnd = xs(rnd);
      v = (k < 16) ? {11'h000, rnd[4:0]} : {14'h0000, rnd[1:0]};
      bus(1'b1, REG_BIDR_BASE + 15'(k), v);
      rd(REG_BIDR_BASE + 15'(k), 1'b1, v);
    end
    // Both connection memories keep whatever entry the host writes.
    for (int k = 0; k < 4; k++)
    begin
      rnd = xs(rnd);
      bus(1'b1, {1'b1, (k < 2) ? MEM_BCM : MEM_LCM, 3'(k), rnd[8:0]}, rnd);
      rd({1'b1, (k < 2) ? MEM_BCM : MEM_LCM, 3'(k), rnd[8:0]}, 1'b1, rnd);
    end
    // Walk the test port to data shift; identification is selected out of reset.
    tck_pulse(1'b0);
    tck_pulse(1'b1);
    tck_pulse(1'b0);
    repeat (33) tck_pulse(1'b0);
    check("idcode lo", tdo_bits[15:0], TB_IDCODE[15:0]);
    check("idcode hi", tdo_bits[31:16], TB_IDCODE[31:16]);
    // Fill backplane entries as driven high and local entries as tristate.
    bus(1'b1, REG_BLOCK, {1'b1, MODE_HIGH, MODE_HIZ, 11'h000});
    // At the first frame start the fast pulse is low for one bit time and the slow one for two.
    @(negedge gfp_slow);
    repeat (20)
    begin
      @(posedge core_clk);
      nf += (gfp_fast === 1'b0);
      ns += (gfp_slow === 1'b0);
    end
    check("fp fast width", 16'(nf), 16'h0008);
    check("fp slow width", 16'(ns), 16'h0010);
    do rd(REG_STATUS, 1'b0, 16'h0000); while (last_rd[4] !== 1'b0 || last_rd[3] !== 1'b1);
    check("startup oe", {bp_oe_b, lo_oe_b}, 16'hffff);
    rd(REG_STATUS, 1'b1, 16'h000a);
    repeat (64) @(posedge core_clk);
    @(negedge core_clk);
    check("bp high", {bp_out, bp_oe_b}, 16'hff00);
    check("lo hiz", {8'h00, lo_oe_b}, 16'h00ff);
    // Refill local entries as zero messages, then give local stream 0 an all-ones message in every channel.
    bus(1'b1, REG_BLOCK, {1'b1, MODE_HIGH, MODE_MSG, 11'h000});
    do rd(REG_STATUS, 1'b0, 16'h0000); while (last_rd[4] !== 1'b0);
    for (int c = 0; c < 512; c++)
      bus(1'b1, {1'b1, MEM_LCM, 3'h0, 9'(c)}, {MODE_MSG, 6'h00, 8'hff});
    repeat (200) @(posedge core_clk);
    check("lo msg", {lo_out, lo_oe_b}, 16'h0100);
    // Self-test rewrites both connection memories and must end done and passed.
    bus(1'b1, REG_BIST, 16'h0001);
    do rd(REG_BIST, 1'b0, 16'h0000); while (last_rd[0] !== 1'b1);
    rd(REG_BIST, 1'b1, 16'h0003);
    finish_test();
  end
endmodule
